//--- bench/rfc_asserts.sv
// Checker for the reset-flag and clock-configuration block.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ps
module rfc_asserts
  import rfc_pkg::*;
(
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     reset_n,
  // Bus
  input wire logic                     hsel,
  input wire logic [7:0]               haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [2:0]               hsize,
  input wire logic [31:0]              hwdata,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // Outputs under watch
  input wire logic                     low_speed_osc_enable,
  input wire logic [3:0]               pll_input_divider,
  input wire logic [4:0]               pll_divide_ratio,
  input wire rfc_pkg::rfc_periph_rst_type periph_resets
);
  import rfc_pkg::*;
  // ****
  // Helpers
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic tk;
  assign tk = hsel && htrans[1] && hreadyout;
  function automatic rfc_periph_rst_type pr(input logic [31:0] d);
    return rfc_periph_rst_type'({d[17], d[18], d[19], d[20], d[22], d[24]});
  endfunction
  logic wr_w;
  assign wr_w = tk && hwrite && hsize == 3'h2;
  // ****
  // Properties
  // ****
  a_ratio_plus_one: assert property (pll_divide_ratio == pll_input_divider + 5'h01)
    else $error("divide ratio is not field plus one");
  a_resp_okay: assert property (!hresp)
    else $error("response not OKAY");
  a_status_wait: assert property (tk && haddr[7:2] == 6'h09 |=> !hreadyout [*2] ##1 hreadyout)
    else $error("status access wait count wrong");
  a_no_wait: assert property (tk && haddr[7:2] != 6'h09 |=> hreadyout)
    else $error("wait inserted on plain register");
  a_idle_ready: assert property (hreadyout && !(hsel && htrans[1]) |=> hreadyout)
    else $error("ready dropped while idle");
  a_prst_write: assert property (wr_w && haddr == 8'h28 |=> ##1 periph_resets == pr($past(hwdata)))
    else $error("peripheral resets do not follow write");
  a_pdiv_write: assert property (wr_w && haddr == 8'h2C |=> ##1 pll_input_divider == $past(hwdata[3:0]))
    else $error("divider does not follow write");
  a_sys_clear: assert property ($rose(reset_n) |-> !low_speed_osc_enable && periph_resets == '0 && pll_input_divider == 4'h0)
    else $error("outputs not cleared by system reset");
  cover property (tk && haddr == 8'h24 && !hwrite);
  cover property (wr_w && haddr == 8'h28);
  cover property ($rose(hreadyout));
endmodule

bind rfc_reset_flags_and_clock_cfg rfc_asserts rfc_asserts_i (.clock, .reset_n, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hreadyout, .hresp, .low_speed_osc_enable,
  .pll_input_divider, .pll_divide_ratio, .periph_resets);

//--- bench/testbench.sv
// Self-checking bench of the reset-flag and clock-configuration block.
// Assumes rfc_pkg is compiled first; the checker binds itself in.
`timescale 1ns/1ps
module testbench;
  import rfc_pkg::*;
  // ****
  // Signals
  // ****
  logic               clock, reset_n, por_reset_n, hsel, hwrite, hreadyout, hresp, irq, rdp;
  logic               low_speed_internal_clock_stable, low_speed_osc_enable;
  logic [7:0]         haddr, acc;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata, hrdata, rn, d;
  logic [3:0]         pll_input_divider;
  logic [4:0]         pll_divide_ratio;
  rfc_causes_type     cause_events;
  rfc_periph_rst_type periph_resets;
  int                 errors, num_checks, cyc;
  logic [31:0]        q[$];
  rfc_reset_flags_and_clock_cfg rfc_reset_flags_and_clock_cfg_i (.clock, .reset_n, .por_reset_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .cause_events, .low_speed_internal_clock_stable, .low_speed_osc_enable,
    .pll_input_divider, .pll_divide_ratio, .periph_resets, .irq);
  // ****
  // Tasks
  // ****
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic [31:0] fl(input logic [7:0] c);
    return {c[7:1], 1'b0, c[0], 23'h0};
  endfunction
  // Single transfer; entered just after a rising edge, so calls run back to back
  task xf(input logic [7:0] a, input logic w, input logic [31:0] v, input logic [2:0] s = 3'h2);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= s;
    do @(posedge clock); while (!hreadyout);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= v;
    do @(posedge clock); while (!hreadyout);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    xf(a, 1'b0, 32'h0);
  endtask
  // ****
  // Clock, monitor and timeout
  // ****
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      close_out;
    end
    if (rdp && hreadyout) chk(hrdata, q.pop_front(), "hrdata");
    if (hsel && htrans[1] && hreadyout) rdp <= !hwrite;
    else if (hreadyout) rdp <= 1'b0;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    reset_n = 0; por_reset_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 2;
    hwdata = 0; cause_events = '0; low_speed_internal_clock_stable = 0;
    errors = 0; num_checks = 0; rn = 32'h54F01C78;
    repeat (3) @(posedge clock);
    reset_n <= 1; por_reset_n <= 1;
    @(posedge clock);
    rd(8'h24, 32'h08000000);
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rn = nx(rn);
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : rn;
      xf(8'h2C, 1'b1, d);
      @(posedge clock);
      chk(32'(pll_divide_ratio), 32'(d[3:0]) + 1, "ratio");
      rd(8'h2C, d & 32'h0000000F);
      xf(8'h28, 1'b1, d);
      @(posedge clock);
      chk(32'(periph_resets), 32'({d[17], d[18], d[19], d[20], d[22], d[24]}), "prst");
      rd(8'h28, d & 32'h015E0000);
    end
    xf(8'h30, 1'b1, 32'hFF);
    xf(8'h27, 1'b1, 32'h01000000, 3'h0);
    rd(8'h24, 32'h0);
    acc = 8'h0;
    for (int k = 0; k < 8; k++) begin
      cause_events <= rfc_causes_type'(8'h01 << k);
      @(posedge clock);
      cause_events <= '0;
      acc = acc | (8'h01 << k);
      rd(8'h24, fl(acc));
    end
    chk(32'(irq), 32'h0, "irq masked");
    xf(8'h34, 1'b1, 32'hFF);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h1, "irq raised");
    rd(8'h30, 32'hFF);
    xf(8'h30, 1'b1, 32'hFF);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0, "irq cleared");
    low_speed_internal_clock_stable <= 1;
    xf(8'h24, 1'b1, 32'h1);
    @(posedge clock);
    chk(32'(low_speed_osc_enable), 32'h1, "osc");
    rd(8'h24, fl(acc) | 32'h3);
    low_speed_internal_clock_stable <= 0;
    rd(8'h24, fl(acc) | 32'h1);
    reset_n <= 0;
    @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    rd(8'h24, fl(acc));
    rd(8'h28, 32'h0);
    xf(8'h40, 1'b1, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    xf(8'h24, 1'b1, 32'h01000000);
    rd(8'h24, 32'h0);
    por_reset_n <= 0;
    @(posedge clock);
    por_reset_n <= 1;
    @(posedge clock);
    rd(8'h24, 32'h08000000);
    repeat (2) @(posedge clock);
    close_out;
  end
endmodule

//--- hdl/rfc_defs.svh
// Offsets, field positions, reset values and timing counts of the reset-flag
// and clock-configuration block. Included by the design.
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RFC_OFF_CSTS     8'h24
`define RFC_OFF_PRST     8'h28
`define RFC_OFF_PDIV     8'h2C
`define RFC_OFF_IRQ_STAT 8'h30
`define RFC_OFF_IRQ_MASK 8'h34

// ****************************************************************
// Field positions
// ****************************************************************
`define RFC_B_OSC_EN     0
`define RFC_B_OSC_RDY    1
`define RFC_B_CORE_FLG   23
`define RFC_B_FLG_CLR    24
`define RFC_B_OPT_FLG    25
`define RFC_B_PIN_FLG    26
`define RFC_B_POR_FLG    27
`define RFC_B_SW_FLG     28
`define RFC_B_IWD_FLG    29
`define RFC_B_WWD_FLG    30
`define RFC_B_LP_FLG     31
`define RFC_B_FLG_LO     23
`define RFC_PRST_MASK    32'h015E0000
`define RFC_PDIV_MASK    32'h0000000F

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RFC_PRST_RST     32'h00000000
`define RFC_PDIV_RST     4'h0
// Cause vector after a power reset: only the power-on/off flag (por member)
`define RFC_FLAGS_POR    8'h08
`define RFC_CSTS_WAIT    2'h1

`endif

//--- hdl/rfc_pkg.sv
// Types shared by the reset-flag and clock-configuration block.
// Assumes rfc_defs.svh is on the include path.
package rfc_pkg;

  // ****************************************************************
  // Latched reset causes, one bit per source (core,opt,pin,por,sw,iwd,wwd,lp)
  // ****************************************************************
  typedef struct packed {
    logic lp;
    logic wwd;
    logic iwd;
    logic sw;
    logic por;
    logic pin;
    logic opt;
    logic core;
  } rfc_causes_type;

  // ****************************************************************
  // Peripheral reset outputs
  // ****************************************************************
  typedef struct packed {
    logic port_a_reset;
    logic port_b_reset;
    logic port_c_reset;
    logic port_d_reset;
    logic port_f_reset;
    logic touch_sense_reset;
  } rfc_periph_rst_type;

  typedef enum logic [1:0] {
    RFC_IDLE,
    RFC_WAIT,
    RFC_DATA
  } rfc_bus_state_type;

endpackage

//--- hdl/rfc_reset_flags_and_clock_cfg.sv
// AHB-Lite slave holding the reset-cause flags, the low-speed oscillator
// control, the peripheral reset bits and the PLL input divider.
// Assumes cause pulses are synchronous to clock and that por_reset_n is
// the power reset, while reset_n is the system reset.
`timescale 1ns/1ps
`include "rfc_defs.svh"

module rfc_reset_flags_and_clock_cfg
  import rfc_pkg::*;
(
  // Clock and resets
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        por_reset_n,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [7:0]                  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Reset cause pulses
  input  wire rfc_pkg::rfc_causes_type     cause_events,
  // Oscillator and clocks
  input  wire logic                        low_speed_internal_clock_stable,
  output logic                             low_speed_osc_enable,
  output logic      [3:0]                  pll_input_divider,
  output logic      [4:0]                  pll_divide_ratio,
  // Peripheral resets
  output rfc_pkg::rfc_periph_rst_type      periph_resets,
  // Interrupt
  output logic                             irq
);
  import rfc_pkg::*;

  // ****************************************************************
  // System-reset domain state
  // ****************************************************************
  typedef struct packed {
    rfc_bus_state_type bst;
    logic [1:0]        wcnt;
    logic              pend_write;
    logic [7:0]        pend_addr;
    logic [3:0]        pend_be;
    logic              osc_en;
    logic              osc_rdy;
    logic [31:0]       prst;
    logic [3:0]        pdiv;
    logic [7:0]        irq_stat;
    logic [7:0]        irq_mask;
    logic [31:0]       rdata;
    logic              clr_req;
  } rfc_state_type;

  rfc_state_type state_r;
  rfc_state_type state_nxt;
  rfc_causes_type flags_r;
  rfc_causes_type flags_nxt;

  // Byte enables of a single aligned access
  function automatic logic [3:0] byte_enables(input logic [2:0] sz, input logic [1:0] a);
    logic [3:0] be;
    be = 4'h0;
    case (sz)
      3'h0: be = 4'h1 << a;
      3'h1: be = a[1] ? 4'hC : 4'h3;
      default: be = 4'hF;
    endcase
    return be;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input rfc_state_type s,
                                            input rfc_causes_type f);
    logic [31:0] v;
    v = 32'h00000000;
    case (a)
      `RFC_OFF_CSTS: begin
        v[`RFC_B_OSC_EN]  = s.osc_en;
        v[`RFC_B_OSC_RDY] = s.osc_rdy;
        v[`RFC_B_CORE_FLG] = f.core;
        v[31:25] = {f.lp, f.wwd, f.iwd, f.sw, f.por, f.pin, f.opt};
      end
      `RFC_OFF_PRST:     v = s.prst & `RFC_PRST_MASK;
      `RFC_OFF_PDIV:     v[3:0] = s.pdiv;
      `RFC_OFF_IRQ_STAT: v[7:0] = s.irq_stat;
      `RFC_OFF_IRQ_MASK: v[7:0] = s.irq_mask;
      default:           v = 32'h00000000;
    endcase
    return v;
  endfunction

  logic        req;
  logic [31:0] wmerged;
  logic [31:0] wmasked;

  // ****************************************************************
  // Bus slave and control registers
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.clr_req = 1'b0;
    req = hsel && hready && htrans[1];
    wmerged = lane_merge(32'h00000000, hwdata, state_r.pend_be);
    wmasked = wmerged;
    state_nxt.osc_rdy = state_r.osc_en && low_speed_internal_clock_stable;
    // Hardware set wins over a software clear in the same cycle
    state_nxt.irq_stat = state_r.irq_stat | cause_events;
    case (state_r.bst)
      RFC_WAIT: begin
        // Status register sits behind a slower path: fixed wait cycles
        if (state_r.wcnt != 2'h0) begin
          state_nxt.wcnt = state_r.wcnt - 2'h1;
        end else begin
          state_nxt.bst = RFC_DATA;
        end
      end
      RFC_DATA: begin
        state_nxt.bst = RFC_IDLE;
      end
      default: begin
        state_nxt.bst = RFC_IDLE;
      end
    endcase
    // Commit a write in the data phase, when hwdata is valid
    if (state_r.pend_write && hreadyout) begin
      case (state_r.pend_addr)
        `RFC_OFF_CSTS: begin
          if (state_r.pend_be[0]) begin
            state_nxt.osc_en = hwdata[`RFC_B_OSC_EN];
          end
          if (state_r.pend_be[3]) begin
            state_nxt.clr_req = hwdata[`RFC_B_FLG_CLR];
          end
        end
        `RFC_OFF_PRST: begin
          wmasked = lane_merge(state_r.prst, hwdata, state_r.pend_be);
          state_nxt.prst = wmasked & `RFC_PRST_MASK;
        end
        `RFC_OFF_PDIV: begin
          if (state_r.pend_be[0]) begin
            state_nxt.pdiv = hwdata[3:0];
          end
        end
        `RFC_OFF_IRQ_STAT: begin
          if (state_r.pend_be[0]) begin
            state_nxt.irq_stat = (state_r.irq_stat & ~wmerged[7:0]) | cause_events;
          end
        end
        `RFC_OFF_IRQ_MASK: begin
          if (state_r.pend_be[0]) begin
            state_nxt.irq_mask = hwdata[7:0];
          end
        end
        default: begin
          state_nxt.irq_mask = state_r.irq_mask;
        end
      endcase
      state_nxt.pend_write = 1'b0;
    end
    if (hreadyout) begin
      state_nxt.pend_write = 1'b0;
      if (req) begin
        state_nxt.pend_write = hwrite;
        state_nxt.pend_addr = {haddr[7:2], 2'b00};
        state_nxt.pend_be = byte_enables(hsize, haddr[1:0]);
        if ({haddr[7:2], 2'b00} == `RFC_OFF_CSTS) begin
          state_nxt.bst = RFC_WAIT;
          state_nxt.wcnt = `RFC_CSTS_WAIT;
        end else begin
          state_nxt.bst = RFC_IDLE;
        end
      end
    end
    // Read data captured so it is registered in the data phase
    if (hreadyout && req && !hwrite) begin
      state_nxt.rdata = read_word({haddr[7:2], 2'b00}, state_nxt, flags_r);
    end else if (state_r.bst == RFC_WAIT && state_r.wcnt == 2'h0) begin
      state_nxt.rdata = read_word(state_r.pend_addr, state_r, flags_r);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '{bst: RFC_IDLE, wcnt: 2'h0, pend_write: 1'b0, pend_addr: 8'h00,
                   pend_be: 4'h0, osc_en: 1'b0, osc_rdy: 1'b0, prst: `RFC_PRST_RST,
                   pdiv: `RFC_PDIV_RST, irq_stat: 8'h00, irq_mask: 8'h00,
                   rdata: 32'h00000000, clr_req: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Reset-cause flags: power-reset domain only
  // ****************************************************************
  always_comb begin
    flags_nxt = flags_r;
    if (state_r.clr_req) begin
      flags_nxt = '0;
    end
    // A cause arriving with the clear still lands
    flags_nxt = flags_nxt | cause_events;
  end

  // Power reset loads its own flag while asserted; flags ignore system reset
  always_ff @(posedge clock or negedge por_reset_n) begin
    if (!por_reset_n) begin
      flags_r <= `RFC_FLAGS_POR;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout = (state_r.bst != RFC_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = state_r.rdata;
  assign low_speed_osc_enable = state_r.osc_en;
  assign pll_input_divider    = state_r.pdiv;
  assign pll_divide_ratio     = {1'b0, state_r.pdiv} + 5'h01;
  assign periph_resets = '{port_a_reset: state_r.prst[17], port_b_reset: state_r.prst[18],
                           port_c_reset: state_r.prst[19], port_d_reset: state_r.prst[20],
                           port_f_reset: state_r.prst[22],
                           touch_sense_reset: state_r.prst[24]};
  assign irq = |(state_r.irq_stat & state_r.irq_mask);

endmodule
